// File: rtl/dcr_pkg.sv
// Register map, field layout and reset values of the DRAM configuration block
package dcr_pkg;
  localparam logic [31:0] BANK_CONTROL_ADDR  = 32'h0000_151c;
  localparam logic [31:0] BASE_ADDRESS_ADDR  = 32'h0000_1520;
  localparam logic [31:0] READ_WAIT_ADDR     = 32'h0000_1524;
  localparam logic [31:0] WRITE_WAIT_ADDR    = 32'h0000_1528;
  localparam logic [31:0] REFRESH_ADDR       = 32'h0000_152c;
  localparam logic [31:0] PARITY_ADDR        = 32'h0000_1530;

  // Writable bits of each register; all others read as zero
  localparam logic [31:0] BANK_CONTROL_MASK  = 32'h0000_0fff;
  localparam logic [31:0] WAIT_STATE_MASK    = 32'h0003_0303;
  localparam logic [31:0] REFRESH_MASK       = 32'h0000_ffff;
  localparam logic [31:0] PARITY_MASK        = 32'h0000_0001;
  localparam logic [31:0] REG_RESET          = 32'h0000_0000;

  // Bank control fields
  localparam int DRIVE_ADDR_BIT   = 11;
  localparam int DRIVE_COL_BIT    = 10;
  localparam int DRIVE_ROW_BIT    = 9;
  localparam int DRIVE_WE_BIT     = 8;
  localparam int TYPE_MSB         = 7;
  localparam int TYPE_LSB         = 3;
  localparam int BANK_ENABLE_BIT  = 0;

  // Wait state fields
  localparam int RAS_CAS_LSB      = 16;
  localparam int CAS_WIDTH_LSB    = 8;
  localparam int RECOVERY_LSB     = 0;

  // Internally reserved address ranges
  localparam logic [31:0] LOW_RSVD_TOP   = 32'h0000_03ff;
  localparam logic [31:0] HIGH_RSVD_BASE = 32'hff00_0000;

  typedef enum logic [1:0] {
    DCR_FAST_PAGE,
    DCR_FAST_PAGE_IL,
    DCR_EDO,
    DCR_RESERVED
  } dcr_mem_type_e;
endpackage

// File: rtl/dcr_config_regs.sv
// DRAM controller configuration registers and window decode
`timescale 1ns/1ps

// How it works
// - Six 32-bit registers at consecutive local words
// - Bank control accessible any time, no idle
// - Bits 11..8 select strong pin drive
// - Type field decodes non-interleaved fast-page banks
// - Decodes interleaved, EDO; 01010 and above reserved
// - Base address undefined until written
// - Bank disabled out of reset
// - No external cycle for reserved ranges
module dcr_config_regs #(
  parameter int LEAF_SIZE_LOG2 = 22
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Local bus register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // Local bus memory decode
  input  wire logic        lb_valid,
  input  wire logic [31:0] lb_addr,
  output logic             mem_claim,
  output logic             ext_cycle_ok,
  // Pin drive strength
  output logic             drive_muxed_row_col_address,
  output logic             drive_column_strobes_n,
  output logic             drive_row_strobes_n,
  output logic             drive_dram_write_enables_n,
  // Decoded arrangement
  output logic             bank_enable,
  output dcr_pkg::dcr_mem_type_e mem_type,
  output logic [2:0]       leaf_count,
  output logic [1:0]       rd_ras_cas,
  output logic [1:0]       rd_cas_width,
  output logic [1:0]       rd_recovery,
  output logic [1:0]       wr_ras_cas,
  output logic [1:0]       wr_cas_width,
  output logic [1:0]       wr_recovery,
  output logic [31:0]      refresh_interval,
  output logic             parity_enable
);

  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] base_q, base_d;
  logic [31:0] rdws_q, rdws_d;
  logic [31:0] wrws_q, wrws_d;
  logic [31:0] refr_q, refr_d;
  logic [31:0] par_q,  par_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic [4:0]  type_code;
  logic [32:0] offset;
  logic [32:0] win_size;

  // Masked write so reserved bits never store
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] msk);
    return (old & ~msk) | (val & msk);
  endfunction

  function automatic logic [1:0] fld2(input logic [31:0] r, input int lsb);
    return r[lsb +: 2];
  endfunction

  always_comb begin
    ctrl_d  = ctrl_q;
    base_d  = base_q;
    rdws_d  = rdws_q;
    wrws_d  = wrws_q;
    refr_d  = refr_q;
    par_d   = par_q;
    // Bank control is writable any time; no idle check needed
    if (reg_wr) begin
      unique case (reg_addr)
        dcr_pkg::BANK_CONTROL_ADDR:
          ctrl_d = wmask(ctrl_q, reg_wdata, dcr_pkg::BANK_CONTROL_MASK);
        dcr_pkg::BASE_ADDRESS_ADDR: base_d = reg_wdata;
        dcr_pkg::READ_WAIT_ADDR:
          rdws_d = wmask(rdws_q, reg_wdata, dcr_pkg::WAIT_STATE_MASK);
        dcr_pkg::WRITE_WAIT_ADDR:
          wrws_d = wmask(wrws_q, reg_wdata, dcr_pkg::WAIT_STATE_MASK);
        dcr_pkg::REFRESH_ADDR:
          refr_d = wmask(refr_q, reg_wdata, dcr_pkg::REFRESH_MASK);
        dcr_pkg::PARITY_ADDR:
          par_d = wmask(par_q, reg_wdata, dcr_pkg::PARITY_MASK);
        default: ;
      endcase
    end
  end

  // Every request is acked, mapped or not, so a stray address cannot hang the bus
  always_comb begin
    rdata_d = rdata_q;
    ack_d   = reg_wr | reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        dcr_pkg::BANK_CONTROL_ADDR: rdata_d = ctrl_q;
        dcr_pkg::BASE_ADDRESS_ADDR: rdata_d = base_q;
        dcr_pkg::READ_WAIT_ADDR:    rdata_d = rdws_q;
        dcr_pkg::WRITE_WAIT_ADDR:   rdata_d = wrws_q;
        dcr_pkg::REFRESH_ADDR:      rdata_d = refr_q;
        dcr_pkg::PARITY_ADDR:       rdata_d = par_q;
        default:                    rdata_d = dcr_pkg::REG_RESET;
      endcase
    end
  end

  // Control registers clear, so the bank starts disabled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q  <= dcr_pkg::REG_RESET;
      rdws_q  <= dcr_pkg::REG_RESET;
      wrws_q  <= dcr_pkg::REG_RESET;
      refr_q  <= dcr_pkg::REG_RESET;
      par_q   <= dcr_pkg::REG_RESET;
    end else begin
      ctrl_q  <= ctrl_d;
      rdws_q  <= rdws_d;
      wrws_q  <= wrws_d;
      refr_q  <= refr_d;
      par_q   <= par_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= dcr_pkg::REG_RESET;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  // Base has no reset on purpose: content is undefined until written
  always_ff @(posedge clk_sys) begin
    base_q <= base_d;
  end

  assign reg_rdata = rdata_q;
  assign reg_ack   = ack_q;

  // Drive strength straight from the register bits
  assign drive_muxed_row_col_address = ctrl_q[dcr_pkg::DRIVE_ADDR_BIT];
  assign drive_column_strobes_n      = ctrl_q[dcr_pkg::DRIVE_COL_BIT];
  assign drive_row_strobes_n         = ctrl_q[dcr_pkg::DRIVE_ROW_BIT];
  assign drive_dram_write_enables_n  = ctrl_q[dcr_pkg::DRIVE_WE_BIT];
  assign bank_enable                 = ctrl_q[dcr_pkg::BANK_ENABLE_BIT];

  assign rd_ras_cas   = fld2(rdws_q, dcr_pkg::RAS_CAS_LSB);
  assign rd_cas_width = fld2(rdws_q, dcr_pkg::CAS_WIDTH_LSB);
  assign rd_recovery  = fld2(rdws_q, dcr_pkg::RECOVERY_LSB);
  assign wr_ras_cas   = fld2(wrws_q, dcr_pkg::RAS_CAS_LSB);
  assign wr_cas_width = fld2(wrws_q, dcr_pkg::CAS_WIDTH_LSB);
  assign wr_recovery  = fld2(wrws_q, dcr_pkg::RECOVERY_LSB);
  assign refresh_interval = refr_q;
  assign parity_enable    = par_q[0];

  assign type_code = ctrl_q[dcr_pkg::TYPE_MSB:dcr_pkg::TYPE_LSB];

  // Leaf count counts interleave leaves; zero marks a reserved code
  always_comb begin
    mem_type   = dcr_pkg::DCR_RESERVED;
    leaf_count = 3'h0;
    casez (type_code)
      5'b00000: begin
        mem_type   = dcr_pkg::DCR_FAST_PAGE;
        leaf_count = 3'h1;
      end
      5'b00001: begin
        mem_type   = dcr_pkg::DCR_FAST_PAGE;
        leaf_count = 3'h2;
      end
      5'b0001?: begin
        mem_type   = dcr_pkg::DCR_FAST_PAGE;
        leaf_count = 3'h4;
      end
      5'b001?0: begin
        mem_type   = dcr_pkg::DCR_FAST_PAGE_IL;
        leaf_count = 3'h2;
      end
      5'b001?1: begin
        mem_type   = dcr_pkg::DCR_FAST_PAGE_IL;
        leaf_count = 3'h4;
      end
      5'b01000: begin
        mem_type   = dcr_pkg::DCR_EDO;
        leaf_count = 3'h1;
      end
      5'b01001: begin
        mem_type   = dcr_pkg::DCR_EDO;
        leaf_count = 3'h2;
      end
      default:  ;
    endcase
  end

  // Range test instead of a mask compare, so a misaligned base is
  // still decoded predictably rather than aliasing
  assign win_size = 33'(leaf_count) << LEAF_SIZE_LOG2;
  assign offset   = {1'b0, lb_addr} - {1'b0, base_q};

  always_comb begin
    ext_cycle_ok = lb_valid && (lb_addr > dcr_pkg::LOW_RSVD_TOP)
                   && (lb_addr < dcr_pkg::HIGH_RSVD_BASE);
    mem_claim    = ext_cycle_ok && bank_enable && (leaf_count != 3'h0)
                   && !offset[32] && (offset < win_size);
  end

endmodule // dcr_config_regs

// File: testbench/dcr_config_regs_sva.sv
// Checker for the DRAM configuration block ports
`timescale 1ns/1ps
module dcr_config_regs_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        lb_valid,
  input wire logic [31:0] lb_addr,
  input wire logic        mem_claim,
  input wire logic        ext_cycle_ok,
  input wire logic        drive_muxed_row_col_address,
  input wire logic        drive_column_strobes_n,
  input wire logic        drive_row_strobes_n,
  input wire logic        drive_dram_write_enables_n,
  input wire logic        bank_enable,
  input dcr_pkg::dcr_mem_type_e mem_type,
  input wire logic [2:0]  leaf_count
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ctl_wr = reg_wr && reg_addr == dcr_pkg::BANK_CONTROL_ADDR;
  a_ack_after_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("no ack");
  a_ack_no_req: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("stray ack");
  a_drive_bits_set: assert property (ctl_wr |=> {drive_muxed_row_col_address,
    drive_column_strobes_n, drive_row_strobes_n, drive_dram_write_enables_n}
    == $past(reg_wdata[11:8])) else $error("drive bits wrong");
  a_bank_en_set: assert property (ctl_wr |=> bank_enable == $past(reg_wdata[0]))
    else $error("enable");
  a_ctl_rsvd_zero: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) ==
    dcr_pkg::BANK_CONTROL_ADDR |-> reg_rdata[31:12] == 20'h00000) else $error("reserved bits");
  a_unmapped_zero: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) ==
    32'h0000_1534 |-> reg_rdata == 32'h0000_0000) else $error("unmapped read");
  a_rsvd_no_cycle: assert property ((lb_addr <= dcr_pkg::LOW_RSVD_TOP || lb_addr >=
    dcr_pkg::HIGH_RSVD_BASE) |-> !ext_cycle_ok && !mem_claim) else $error("reserved range");
  a_claim_enabled: assert property (mem_claim |->
    bank_enable && ext_cycle_ok && lb_valid) else $error("claim while off");
  a_reset_off: assert property ($fell(rst) |-> !bank_enable && !mem_claim)
    else $error("enabled after reset");
  a_type_rsvd_none: assert property (mem_type == dcr_pkg::DCR_RESERVED |->
    leaf_count == 3'h0 && !mem_claim) else $error("reserved type");
  cover property (mem_claim);
  cover property (reg_ack && $past(reg_rd));
  cover property (mem_type == dcr_pkg::DCR_EDO && leaf_count == 3'h2);
endmodule // dcr_config_regs_sva
bind dcr_config_regs dcr_config_regs_sva u_sva (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_ack, .lb_valid, .lb_addr, .mem_claim, .ext_cycle_ok,
  .drive_muxed_row_col_address, .drive_column_strobes_n, .drive_row_strobes_n,
  .drive_dram_write_enables_n, .bank_enable, .mem_type, .leaf_count);

// File: testbench/dcr_dram_model.sv
// Behavioural DRAM array behind the controller, counting claimed accesses
`timescale 1ns/1ps
module dcr_dram_model (
  input  wire logic clk_sys,
  input  wire logic mem_claim,
  output int        hits
);
  // One uniform 32-bit wide bank type only, no mixing
  int count_q = 0;
  always @(posedge clk_sys) begin
    if (mem_claim) begin
      count_q <= count_q + 1;
    end
  end
  assign hits = count_q;
endmodule // dcr_dram_model

// File: testbench/dcr_config_regs_tb.sv
// Self-checking bench for the DRAM configuration block
`timescale 1ns/1ps
module dcr_config_regs_tb;
  logic        clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, lb_valid = 0;
  logic [31:0] reg_addr = 0, reg_wdata = 0, lb_addr = 0, reg_rdata;
  logic        reg_ack, mem_claim, ext_cycle_ok, bank_enable, d_a, d_c, d_r, d_w;
  dcr_pkg::dcr_mem_type_e mem_type;
  logic [2:0]  leaf_count;
  logic [1:0]  rrc, rcp, rrv, wrc, wcp, wrv;
  logic [31:0] refr;
  logic        par_en;
  int          n_fail = 0, samples_checked = 0, cyc = 0, hits;
  // Entries are type code, mem type, leaf count
  logic [9:0]  tt[12] = '{10'h001, 10'h022, 10'h044, 10'h064, 10'h08a, 10'h0ca,
                          10'h0ac, 10'h0ec, 10'h111, 10'h132, 10'h158, 10'h218};
  logic [31:0] msk[6] = '{32'h0000_0fff, 32'hffff_ffff, 32'h0003_0303, 32'h0003_0303,
                          32'h0000_ffff, 32'h0000_0001};
  always #2.5 clk_sys = ~clk_sys;
  dcr_config_regs #(.LEAF_SIZE_LOG2(22)) DUT (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_ack, .lb_valid, .lb_addr, .mem_claim, .ext_cycle_ok,
    .drive_muxed_row_col_address(d_a), .drive_column_strobes_n(d_c),
    .drive_row_strobes_n(d_r), .drive_dram_write_enables_n(d_w), .bank_enable, .mem_type,
    .leaf_count, .rd_ras_cas(rrc), .rd_cas_width(rcp), .rd_recovery(rrv), .wr_ras_cas(wrc),
    .wr_cas_width(wcp), .wr_recovery(wrv), .refresh_interval(refr), .parity_enable(par_en));
  dcr_dram_model u_dram (.clk_sys, .mem_claim, .hits);
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk_sys) reg_wr = 0;
    chk(reg_ack, 1);
  endtask
  task automatic rd(input logic [31:0] a, e);
    @(negedge clk_sys) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk_sys) reg_rd = 0;
    chk(reg_ack, 1);
    chk(reg_rdata, e);
  endtask
  task automatic lb(input logic [31:0] a, input logic claim, ok);
    @(negedge clk_sys) lb_addr = a;
    #1 chk({mem_claim, ext_cycle_ok}, {claim, ok});
  endtask
  task automatic end_of_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Ceiling well above the roughly 110 cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 0;
    lb_valid = 1;
    chk({d_a, d_c, d_r, d_w, bank_enable}, 0);
    chk({rrc, rcp, rrv, wrc, wcp, wrv, par_en}, 0);
    chk(refr, 0);
    // Base still undefined here; a disabled bank must not claim
    lb(32'h0040_0000, 0, 1);
    for (int i = 0; i < 6; i++) if (i != 1) rd(32'h0000_151c + 4 * i, 0);
    for (int i = 0; i < 6; i++) begin
      wr(32'h0000_151c + 4 * i, 32'hffff_ffff);
      rd(32'h0000_151c + 4 * i, msk[i]);
    end
    wr(32'h0000_1534, 32'hffff_ffff);
    rd(32'h0000_1534, 0);
    chk({rrc, rcp, rrv, wrc, wcp, wrv}, 12'hfff);
    chk(refr, 32'h0000_ffff);
    chk(par_en, 1);
    for (int i = 0; i < 4; i++) begin
      wr(dcr_pkg::BANK_CONTROL_ADDR, 32'h100 << i);
      chk({d_a, d_c, d_r, d_w}, 4'h1 << i);
    end
    for (int i = 0; i < 12; i++) begin
      wr(dcr_pkg::BANK_CONTROL_ADDR, {24'h0, tt[i][9:5], 3'h0});
      chk({mem_type, leaf_count}, tt[i][4:0]);
    end
    // Banks off, base aligned and clear of reserved ranges, then enable
    wr(dcr_pkg::READ_WAIT_ADDR, 32'h0001_0203);
    wr(dcr_pkg::WRITE_WAIT_ADDR, 32'h0002_0301);
    chk({rrc, rcp, rrv, wrc, wcp, wrv}, 12'h6ed);
    wr(dcr_pkg::BASE_ADDRESS_ADDR, 32'h0040_0000);
    wr(dcr_pkg::BANK_CONTROL_ADDR, 32'h0000_0001);
    lb_valid = 1;
    lb(32'h0040_0000, 1, 1);
    lb(32'h007f_fffc, 1, 1);
    lb(32'h0080_0000, 0, 1);
    lb(32'h003f_fffc, 0, 1);
    // Reset in mid-run drops the enable while the base keeps a value
    @(negedge clk_sys) rst = 1;
    @(negedge clk_sys) rst = 0;
    chk({bank_enable, mem_claim}, 0);
    lb(32'h0040_0000, 0, 1);
    wr(dcr_pkg::BASE_ADDRESS_ADDR, 32'h0040_0000);
    wr(dcr_pkg::BANK_CONTROL_ADDR, 32'h0000_0001);
    lb(32'h0040_0000, 1, 1);
    wr(dcr_pkg::BANK_CONTROL_ADDR, 32'h0000_0000);
    lb(32'h0040_0000, 0, 1);
    lb(32'h0000_03fc, 0, 0);
    lb(32'h0000_0400, 0, 1);
    lb(32'hff00_0000, 0, 0);
    lb(32'hfeff_fffc, 0, 1);
    chk(hits > 0, 1);
    end_of_test;
  end
endmodule // dcr_config_regs_tb
